/* inc/can_xcvr_map.svh */
// Offsets, field positions, reset values and timing counts of the transceiver
`ifndef CAN_XCVR_MAP_SVH
`define CAN_XCVR_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define REG_CTRL      12'h000
`define REG_STATUS    12'h004
`define REG_IRQ_STAT  12'h008
`define REG_IRQ_EN    12'h00c
`define REG_IRQ_CLR   12'h010

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_USE_REG  0
`define CTRL_EN_N     1
`define CTRL_RO_N     2
`define CTRL_RST_VAL  32'h0000_0006
`define EV_TIMEOUT    0
`define EV_THERMAL    1
`define EV_MODE_DONE  2
`define EV_W          3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define TXD_TO_MIN_NS 4500000
`define TXD_REL_NS    200
`define MODE_TIME_NS  20000
// Least times round up
`define TO_CYCLES  ((`TXD_TO_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REL_CYCLES ((`TXD_REL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Longest time rounds down
`define MODE_CYCLES (`MODE_TIME_NS / `CLK_PERIOD_NS)

`endif

/* inc/can_xcvr_pkg.sv */
// Types shared by the transceiver control files
`default_nettype none
package can_xcvr_pkg;
  typedef enum logic [1:0] {
    MODE_SAVE,
    MODE_RX_ONLY,
    MODE_NORMAL
  } xcvr_mode_t;
endpackage
`default_nettype wire

/* design/txd_timeout.sv */
// Dominant time-out watchdog on the transmit input
`default_nettype none
`include "can_xcvr_map.svh"
module txd_timeout
  import can_xcvr_pkg::*;
#(
  parameter int unsigned TO_CYC  = `TO_CYCLES,
  parameter int unsigned REL_CYC = `REL_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Inputs
  input  wire logic txdIn,
  input  wire logic saveMode,
  // Status
  output logic      timedOut
);
  logic [17:0] domCnt_q;
  logic [7:0]  relCnt_q;
  logic        timedOut_q;

  assign timedOut = timedOut_q;

  // Count dominant time; saturates once the time-out latches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      domCnt_q <= '0;
    end else if (txdIn || saveMode) begin
      domCnt_q <= '0;
    end else if (!timedOut_q) begin
      domCnt_q <= domCnt_q + 18'h00001;
    end
  end

  // Count recessive time; any low restarts it, so a count means an edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      relCnt_q  <= '0;
    end else begin
      if (!txdIn) begin
        relCnt_q <= '0;
      end else if (relCnt_q != 8'hff) begin
        relCnt_q <= relCnt_q + 8'h01;
      end
    end
  end

  // Latch; never earlier than the minimum, cleared only after release or in save mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timedOut_q <= 1'b0;
    end else if (saveMode) begin
      timedOut_q <= 1'b0;
    end else if (!timedOut_q && 32'(domCnt_q) >= TO_CYC - 1 && !txdIn) begin
      timedOut_q <= 1'b1;
    end else if (timedOut_q && txdIn && 32'(relCnt_q) + 1 >= REL_CYC) begin
      timedOut_q <= 1'b0;
    end
  end

  a_timeout_min: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(timedOut_q) |-> 32'(domCnt_q) >= TO_CYC - 1)
    else $error("dominant time-out fired early");
endmodule
`default_nettype wire

/* design/mode_sequencer.sv */
// Mode decode and transition timer
`default_nettype none
`include "can_xcvr_map.svh"
module mode_sequencer
  import can_xcvr_pkg::*;
#(
  parameter int unsigned MODE_CYC = `MODE_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Mode pins, active low
  input  wire logic       enNIn,
  input  wire logic       roNIn,
  // Result
  output xcvr_mode_t      mode,
  output logic            inTransit,
  output logic            transitDone
);
  xcvr_mode_t  mode_q;
  xcvr_mode_t  modeReq;
  logic [15:0] tCnt_q;

  // Pin decode: enable high means save regardless of the other pin
  always_comb begin
    if (enNIn) begin
      modeReq = MODE_SAVE;
    end else if (!roNIn) begin
      modeReq = MODE_RX_ONLY;
    end else begin
      modeReq = MODE_NORMAL;
    end
  end

  assign mode        = mode_q;
  assign inTransit   = (tCnt_q != 16'h0000);
  assign transitDone = (tCnt_q == 16'h0001);

  // Leaving save starts the timer; normal and rx-only swap freely
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_SAVE;
      tCnt_q <= '0;
    end else begin
      mode_q <= modeReq;
      if (mode_q == MODE_SAVE && modeReq != MODE_SAVE) begin
        tCnt_q <= 16'(MODE_CYC);
      end else if (modeReq == MODE_SAVE) begin
        tCnt_q <= '0;
      end else if (tCnt_q != 16'h0000) begin
        tCnt_q <= tCnt_q - 16'h0001;
      end
    end
  end

  a_swap_free: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_q != MODE_SAVE && modeReq != MODE_SAVE && !inTransit)
      |=> !inTransit)
    else $error("normal/rx-only swap started a transition");
endmodule
`default_nettype wire

/* design/can_xcvr_ctrl.sv */
// Transceiver mode, dominant time-out and thermal fallback control
`default_nettype none
`include "can_xcvr_map.svh"
module can_xcvr_ctrl
  import can_xcvr_pkg::*;
#(
  parameter int unsigned TO_CYC   = `TO_CYCLES,
  parameter int unsigned MODE_CYC = `MODE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Controller pins
  input  wire logic        txdIn,
  input  wire logic        enable_n_pin,
  input  wire logic        enable_n_pin_oe_n,
  input  wire logic        receive_only_select_n_pin,
  input  wire logic        receive_only_select_n_pin_oe_n,
  output logic             rxdOut,
  // Analogue front end
  input  wire logic        busDominant,
  input  wire logic        overTemp,
  output logic             txDriveDom,
  output logic             rxEnable,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq
);
  // -------------------------------------------------------------
  // Pin conditioning
  // -------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic        enNEff;
  logic        roNEff;
  logic        txdEff;

  // Undriven pins (oe_n high) act as pulled up
  always_comb begin
    enNEff = enable_n_pin | enable_n_pin_oe_n;
    roNEff = receive_only_select_n_pin | receive_only_select_n_pin_oe_n;
    if (ctrl_q[`CTRL_USE_REG]) begin
      enNEff = ctrl_q[`CTRL_EN_N];
      roNEff = ctrl_q[`CTRL_RO_N];
    end
  end

  // -------------------------------------------------------------
  // Submodules
  // -------------------------------------------------------------
  xcvr_mode_t mode;
  logic       inTransit;
  logic       transitDone;
  logic       timedOut;
  logic       thermal_q;

  mode_sequencer #(.MODE_CYC(MODE_CYC)) u_mode (
    .clk         (clk),
    .arst_n      (arst_n),
    .enNIn       (enNEff),
    .roNIn       (roNEff),
    .mode        (mode),
    .inTransit   (inTransit),
    .transitDone (transitDone)
  );

  // Transmit path is blocked during transition, input seen recessive
  assign txdEff = txdIn | inTransit;

  txd_timeout #(.TO_CYC(TO_CYC)) u_to (
    .clk      (clk),
    .arst_n   (arst_n),
    .txdIn    (txdEff),
    .saveMode (mode == MODE_SAVE),
    .timedOut (timedOut)
  );

  // -------------------------------------------------------------
  // Output stage
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thermal_q <= 1'b0;
    end else begin
      thermal_q <= overTemp;
    end
  end

  // Registered drive and receive outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txDriveDom <= 1'b0;
      rxEnable   <= 1'b0;
      rxdOut     <= 1'b1;
    end else begin
      // all conditions; thermal falls back to receive only
      txDriveDom <= (mode == MODE_NORMAL) && !inTransit && !timedOut &&
                    !thermal_q && !txdIn;
      rxEnable   <= (mode != MODE_SAVE) && !inTransit;
      if (mode == MODE_SAVE || inTransit) begin
        rxdOut <= 1'b1;
      end else begin
        rxdOut <= !busDominant;
      end
    end
  end

  // -------------------------------------------------------------
  // Interrupt status
  // -------------------------------------------------------------
  logic [`EV_W-1:0] irqStat_q;
  logic [`EV_W-1:0] irqEn_q;
  logic [`EV_W-1:0] evt;
  logic             timedOutPrev_q;
  logic             thermalPrev_q;
  logic             wrStrobe;
  logic             clrHit;

  assign wrStrobe = psel && penable && pwrite;
  assign clrHit   = wrStrobe && paddr == `REG_IRQ_CLR;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timedOutPrev_q <= 1'b0;
      thermalPrev_q  <= 1'b0;
    end else begin
      timedOutPrev_q <= timedOut;
      thermalPrev_q  <= thermal_q;
    end
  end

  always_comb begin
    evt = '0;
    evt[`EV_TIMEOUT]   = timedOut && !timedOutPrev_q;
    evt[`EV_THERMAL]   = thermal_q && !thermalPrev_q;
    evt[`EV_MODE_DONE] = transitDone;
  end

  // Set beats clear so a simultaneous event is never lost
  genvar gi;
  generate
    for (gi = 0; gi < `EV_W; gi++) begin : g_stat
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          irqStat_q[gi] <= 1'b0;
        end else if (evt[gi]) begin
          irqStat_q[gi] <= 1'b1;
        end else if (clrHit && pwdata[gi]) begin
          irqStat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(irqStat_q & irqEn_q);

  // -------------------------------------------------------------
  // APB register file
  // -------------------------------------------------------------
  assign pready = 1'b1;

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      if (paddr == `REG_CTRL || paddr == `REG_STATUS ||
          paddr == `REG_IRQ_STAT || paddr == `REG_IRQ_EN ||
          paddr == `REG_IRQ_CLR) begin
        pslverr = 1'b0;
      end else begin
        pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q  <= `CTRL_RST_VAL;
      irqEn_q <= '0;
    end else if (wrStrobe) begin
      if (paddr == `REG_CTRL) begin
        ctrl_q <= {29'h0, pwdata[2:0]};
      end else if (paddr == `REG_IRQ_EN) begin
        irqEn_q <= pwdata[`EV_W-1:0];
      end
    end
  end

  // Read data registered in the setup cycle, valid in access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `REG_CTRL) begin
        prdata <= ctrl_q;
      end else if (paddr == `REG_STATUS) begin
        prdata <= {25'h0, rxdOut, txDriveDom, thermal_q, timedOut,
                   inTransit, mode};
      end else if (paddr == `REG_IRQ_STAT) begin
        prdata <= {29'h0, irqStat_q};
      end else if (paddr == `REG_IRQ_EN) begin
        prdata <= {29'h0, irqEn_q};
      end else begin
        prdata <= '0;
      end
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  sequence s_leave_save;
    (mode == MODE_SAVE) ##1 (mode != MODE_SAVE);
  endsequence

  a_rxd_forced: assert property (@(posedge clk) disable iff (!arst_n)
    s_leave_save |=> rxdOut)
    else $error("rxd not high after leaving save");

  a_tx_blocked: assert property (@(posedge clk) disable iff (!arst_n)
    inTransit |=> !txDriveDom)
    else $error("dominant drive during transition");

  a_thermal_off: assert property (@(posedge clk) disable iff (!arst_n)
    thermal_q |=> !txDriveDom)
    else $error("drive while overtemperature");

  a_timeout_off: assert property (@(posedge clk) disable iff (!arst_n)
    timedOut |=> !txDriveDom)
    else $error("drive while time-out latched");

  a_rx_follow: assert property (@(posedge clk) disable iff (!arst_n)
    (mode != MODE_SAVE && !inTransit) |=> rxdOut == !$past(busDominant))
    else $error("rxd does not follow bus");

  a_save_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == MODE_SAVE) [*2] |-> !timedOut)
    else $error("time-out survived save mode");

  a_rx_thermal: assert property (@(posedge clk) disable iff (!arst_n)
    (thermal_q && mode != MODE_SAVE && !inTransit) |=> rxEnable)
    else $error("receiver off in thermal shutdown");

  a_drive_ok: assert property (@(posedge clk) disable iff (!arst_n)
    txDriveDom |-> $past(mode) == MODE_NORMAL && !$past(txdIn))
    else $error("dominant drive without cause");
endmodule
`default_nettype wire

/* verif/can_ctrl_model.sv */
// Behavioural CAN controller driving the transmit and mode pins
`default_nettype none
module can_ctrl_model #(
  parameter int MODE_CYC = 20
) (
  // Clock
  input  wire logic clk,
  // Pins toward the transceiver
  output var logic  txd,
  output var logic  enN,
  output var logic  enOeN,
  output var logic  roN,
  output var logic  roOeN
);
  timeunit 1ns;
  timeprecision 1ns;

  // -------------------------------------------------------------
  // Pin drivers
  // -------------------------------------------------------------
  // Released mode pins sit at the pull-up level, never at a stale value
  initial begin
    txd = 1'b1;
    {enN, enOeN, roN, roOeN} = 4'hf;
  end

  // 0 released, 1 rx-only, 2 normal, 3 enable high with select low
  task automatic set_mode(input int m);
    enOeN <= (m == 0);
    roOeN <= (m == 0);
    enN <= (m == 0 || m == 3);
    roN <= !(m == 1 || m == 3);
  endtask

  // Nothing is relied upon until the transition time has run out
  task automatic settle();
    repeat (MODE_CYC + 4) @(posedge clk);
  endtask

  task automatic set_txd(input logic v);
    txd <= v;
  endtask

  // Dominant phases stay short unless a stuck input is ordered
  task automatic dominant(input int n);
    txd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  // Recessive is held past the release time after a dominant phase
  task automatic release_txd(input int relCyc);
    txd <= 1'b1;
    repeat (relCyc + 2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* verif/can_transceiver_mode_fault_ctrl_tb_top.sv */
// Self-checking bench of the transceiver mode and fault control
`default_nettype none
`include "can_xcvr_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module can_transceiver_mode_fault_ctrl_tb_top import can_xcvr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO = 50;
  localparam int MC = 20;
  localparam int REL = `REL_CYCLES;
  // Design pins, bus and bench state
  logic        clk, arst_n, txdIn, enable_n_pin, enable_n_pin_oe_n;
  logic        receive_only_select_n_pin, receive_only_select_n_pin_oe_n;
  logic        rxdOut, busDominant, overTemp, txDriveDom, rxEnable, irq;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count, tests_run, seed, mMode, mTo, mTherm, n;

  // -------------------------------------------------------------
  // Clock, design and controller
  // -------------------------------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;

  can_xcvr_ctrl #(.TO_CYC(TO), .MODE_CYC(MC)) dut_u (
    .clk, .arst_n, .txdIn, .enable_n_pin, .enable_n_pin_oe_n,
    .receive_only_select_n_pin, .receive_only_select_n_pin_oe_n,
    .rxdOut, .busDominant, .overTemp, .txDriveDom, .rxEnable, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);

  can_ctrl_model #(.MODE_CYC(MC)) ctl_u (
    .clk, .txd(txdIn), .enN(enable_n_pin), .enOeN(enable_n_pin_oe_n),
    .roN(receive_only_select_n_pin),
    .roOeN(receive_only_select_n_pin_oe_n));

  // APB master: request held until pready, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Design against the bench's own mode and fault state
  task automatic check_all();
    logic eTx;
    logic eRx;
    eTx = mMode == 2 && !mTo && !mTherm && txdIn === 1'b0;
    eRx = mMode == 0 || !busDominant;
    `CHK(txDriveDom, eTx)
    `CHK(rxdOut, eRx)
    `CHK(rxEnable, mMode != 0)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK(rd[1:0], 2'(mMode))
    `CHK(rd[3], mTo != 0)
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang is cut well beyond the length of the scenarios
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial begin
    seed = 86861;
    {arst_n, psel, penable, pwrite, busDominant, overTemp} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check_all();
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(rd, `CTRL_RST_VAL)
    // Unmapped places are refused, clear register reads zero
    apb(1'b1, 12'h024, $random(seed));
    apb(1'b0, 12'h020, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b0, `REG_IRQ_CLR, 32'h0);
    `CHK({err, rd}, 33'h0)
    // Leaving save: receive held high, transmit path blocked
    busDominant <= 1'b1;
    ctl_u.set_txd(1'b0);
    ctl_u.set_mode(2);
    repeat (4) @(posedge clk);
    `CHK(rxdOut, 1'b1)
    `CHK(txDriveDom, 1'b0)
    ctl_u.set_txd(1'b1);
    ctl_u.settle();
    mMode = 2;
    check_all();
    // Short dominant phases pass untouched; bus level is random
    for (int i = 0; i < 6; i++) begin
      n = 8 + int'($unsigned($random(seed)) % 32);
      busDominant <= 1'($random(seed));
      ctl_u.dominant(n);
      `CHK(txDriveDom, 1'b1)
      `CHK(rxdOut, !busDominant)
      ctl_u.release_txd(REL);
      `CHK(txDriveDom, 1'b0)
    end
    // Stuck dominant input: time-out, interrupt mask and clear
    apb(1'b1, `REG_IRQ_CLR, 32'h7);
    apb(1'b1, `REG_IRQ_EN, 32'h1);
    `CHK(irq, 1'b0)
    ctl_u.set_txd(1'b0);
    repeat (TO + 5) @(posedge clk);
    mTo = 1;
    check_all();
    `CHK(irq, 1'b1)
    apb(1'b1, `REG_IRQ_EN, 32'h0);
    `CHK(irq, 1'b0)
    apb(1'b1, `REG_IRQ_EN, 32'h1);
    `CHK(irq, 1'b1)
    check_all();
    ctl_u.release_txd(REL);
    mTo = 0;
    ctl_u.set_txd(1'b0);
    repeat (3) @(posedge clk);
    check_all();
    apb(1'b1, `REG_IRQ_CLR, 32'h1);
    `CHK(irq, 1'b0)
    // A latched time-out is dropped by entering save
    repeat (TO + 5) @(posedge clk);
    mTo = 1;
    check_all();
    ctl_u.set_mode(0);
    ctl_u.settle();
    {mMode, mTo} = '0;
    check_all();
    ctl_u.set_txd(1'b1);
    ctl_u.set_mode(2);
    ctl_u.settle();
    mMode = 2;
    // Normal and receive-only swap without touching the receive output
    busDominant <= 1'b1;
    ctl_u.set_mode(1);
    repeat (3) @(posedge clk);
    `CHK(rxdOut, 1'b0)
    mMode = 1;
    ctl_u.set_txd(1'b0);
    check_all();
    ctl_u.set_mode(2);
    repeat (3) @(posedge clk);
    `CHK(rxdOut, 1'b0)
    `CHK(txDriveDom, 1'b1)
    mMode = 2;
    // Overtemperature: transmitter off, receiver keeps working
    overTemp <= 1'b1;
    repeat (3) @(posedge clk);
    mTherm = 1;
    for (int i = 0; i < 2; i++) begin
      busDominant <= i[0];
      repeat (3) @(posedge clk);
      check_all();
    end
    // Every event kind has latched by now: time-out, thermal, mode done
    apb(1'b0, `REG_IRQ_STAT, 32'h0);
    `CHK(rd, 32'h0000_0007)
    overTemp <= 1'b0;
    mTherm = 0;
    repeat (3) @(posedge clk);
    check_all();
    // Enable high selects save whatever the select pin says
    ctl_u.set_txd(1'b1);
    ctl_u.set_mode(3);
    mMode = 0;
    ctl_u.settle();
    check_all();
    // Register override selects rx-only while the pins ask for save
    apb(1'b1, `REG_CTRL, 32'h1);
    ctl_u.settle();
    mMode = 1;
    check_all();
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(rd, 32'h0000_0001)
    // Reset in mid-run drops the override and returns to save
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    mMode = 0;
    check_all();
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(rd, `CTRL_RST_VAL)
    report_and_stop();
  end
endmodule
`default_nettype wire
